// ---- design/spm_pkg.sv ----
package spm_pkg;
	// Data width of the port
	localparam int SPM_DW = 8;
	// Register addresses on the special-function bus
	localparam logic [7:0] SPM_ADDR_CTRL = 8'hbc;
	localparam logic [7:0] SPM_ADDR_STAT = 8'hbd;
	localparam logic [7:0] SPM_ADDR_DATA = 8'hbe;
	// Control register field positions
	localparam int SPM_C_ON = 7;
	localparam int SPM_C_MST = 6;
	localparam int SPM_C_CLOCK_IDLE_LEVEL = 5;
	localparam int SPM_C_CLOCK_PHASE = 4;
	localparam int SPM_C_SSIGN = 3;
	localparam int SPM_C_ORDER = 2;
	localparam int SPM_C_RATE_HI = 1;
	localparam int SPM_C_RATE_LO = 0;
	// Status register field positions
	localparam int SPM_S_DONE = 7;
	localparam int SPM_S_CLASH = 6;
	localparam int SPM_S_FAULT = 5;
	localparam int SPM_S_OVF = 4;
	localparam int SPM_S_FULL = 3;
	localparam int SPM_S_BUSY = 2;
	// Reset values
	localparam logic [7:0] SPM_CTRL_RST = 8'h00;
	localparam logic [7:0] SPM_DATA_RST = 8'h00;
	// Sixteen SCK edges make one byte; index of the last edge
	localparam logic [4:0] SPM_EDGE_LAST = 5'h0f;
	// Width of the master clock-rate divider counter
	localparam int SPM_DIV_W = 3;

	typedef enum logic {
		SPM_IDLE = 1'b0,
		SPM_RUN = 1'b1
	} spm_state_t;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} spm_pin_in_t;

	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic mosi;
		logic mosi_oe;
		logic miso;
		logic miso_oe;
	} spm_pin_out_t;
endpackage

// ---- design/spm_rate_div.sv ----
`timescale 1ns/100ps
module spm_rate_div import spm_pkg::*; #(
	parameter int CW = SPM_DIV_W
) (
	input logic clk_sys,
	input logic nrst,
	input logic run,
	input logic [1:0] rate,
	output logic tick
);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic [CW-1:0] lim;

	// Half SCK period is 1, 2, 4 or 8 system cycles
	always_comb begin
		lim = CW'((4'd1 << rate) - 4'd1);
		tick = run && (cnt_reg == lim);
		if (!run || tick) begin
			cnt_next = '0;
		end else begin
			cnt_next = cnt_reg + CW'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule

// ---- design/spm_port.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - master_select 1 master, 0 slave
// - port works only while port_on set
// - master SCK is sysclk divided 2/4/8/16
// - slave ignores clock_rate, uses external SCK
// - master data write when idle starts shifting
// - master busy from write to eighth period
// - master end: done, buffer copy, full set
// - slave starts on SS low or enable
// - slave copies only if buffer empty or read in the same cycle, else overrun
// - slave busy follows SS or port_on
// - SCK idles at clock_idle_level
// - clock_phase picks sample and shift edges
// - bit_order picks MSB or LSB first
// - ignore bit drops SS; deselected slave idles
// - master SS low: fault, clear on/master
// - busy write sets clash, shift untouched
// - done flag cleared by vector or zero
// - full/overrun cleared by zero or data read
// - data read returns receive buffer
// - both ends share polarity and phase
// - pin directions follow master or slave
module spm_port import spm_pkg::*; (
	input logic clk_sys,
	input logic nrst,
	input logic [7:0] sfr_addr,
	input logic sfr_wr,
	input logic sfr_rd,
	input logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input logic int_en,
	input logic int_ack,
	input spm_pin_in_t pins_i,
	output spm_pin_out_t pins_o,
	output logic irq
);
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] rbuf_reg, rbuf_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [4:0] cnt_reg, cnt_next;
	spm_state_t st_reg, st_next;
	logic sck_reg, sck_next;
	logic dout_reg, dout_next;
	logic sck_prev_reg;
	logic tdone_reg, tdone_next;
	logic clash_reg, clash_next;
	logic fault_reg, fault_next;
	logic ovf_reg, ovf_next;
	logic full_reg, full_next;
	logic irq_reg, irq_next;
	spm_pin_out_t pins_reg, pins_next;
	logic wr_ctrl, wr_stat, wr_data, rd_data;
	logic on, mst, clock_idle_level, clock_phase, ssign, bit_order;
	logic busy, slv_sel, fault_cond, tick, byte_done, edge_hit, lead, sample, din;

	// First bit to present on the data pin
	function automatic logic first_bit(input logic [7:0] d, input logic lsb);
		return lsb ? d[0] : d[7];
	endfunction

	// Shift one received bit into the byte
	function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb);
		return lsb ? {b, d[7:1]} : {d[6:0], b};
	endfunction

	// Register decode and control fields
	assign wr_ctrl = sfr_wr && (sfr_addr == SPM_ADDR_CTRL);
	assign wr_stat = sfr_wr && (sfr_addr == SPM_ADDR_STAT);
	assign wr_data = sfr_wr && (sfr_addr == SPM_ADDR_DATA);
	assign rd_data = sfr_rd && (sfr_addr == SPM_ADDR_DATA);
	assign on = ctrl_reg[SPM_C_ON];
	assign mst = ctrl_reg[SPM_C_MST];
	assign clock_idle_level = ctrl_reg[SPM_C_CLOCK_IDLE_LEVEL];
	assign clock_phase = ctrl_reg[SPM_C_CLOCK_PHASE];
	assign ssign = ctrl_reg[SPM_C_SSIGN];
	assign bit_order = ctrl_reg[SPM_C_ORDER];

	// Selection, busy and fault conditions
	assign slv_sel = on && !mst && (ssign || !pins_i.ss_n);
	assign busy = mst ? (st_reg == SPM_RUN) : slv_sel;
	assign fault_cond = on && mst && !ssign && !pins_i.ss_n;

	// Master clock divider, only running during a master byte
	spm_rate_div #(.CW(SPM_DIV_W)) spm_rate_div_i (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.run(st_reg == SPM_RUN),
		.rate(ctrl_reg[SPM_C_RATE_HI:SPM_C_RATE_LO]),
		.tick(tick)
	);

	// Edge classification shared by master and slave
	always_comb begin
		if (mst) begin
			edge_hit = tick;
			lead = !cnt_reg[0];
			din = pins_i.miso;
		end else begin
			edge_hit = slv_sel && (pins_i.sck != sck_prev_reg);
			lead = (pins_i.sck != clock_idle_level);
			din = pins_i.mosi;
		end
		sample = lead ^ clock_phase;
	end

	// Next-state logic for registers, flags and the shift engine
	always_comb begin
		ctrl_next = ctrl_reg;
		sh_next = sh_reg;
		rbuf_next = rbuf_reg;
		cnt_next = cnt_reg;
		st_next = st_reg;
		sck_next = sck_reg;
		dout_next = dout_reg;
		tdone_next = tdone_reg;
		clash_next = clash_reg;
		fault_next = fault_reg;
		ovf_next = ovf_reg;
		full_next = full_reg;
		byte_done = 1'b0;
		// Software writes and clears
		if (wr_ctrl) begin
			ctrl_next = sfr_wdata;
		end
		if (wr_stat) begin
			tdone_next = tdone_reg && sfr_wdata[SPM_S_DONE];
			clash_next = clash_reg && sfr_wdata[SPM_S_CLASH];
			fault_next = fault_reg && sfr_wdata[SPM_S_FAULT];
			ovf_next = ovf_reg && sfr_wdata[SPM_S_OVF];
			full_next = full_reg && sfr_wdata[SPM_S_FULL];
		end
		if (rd_data) begin
			full_next = 1'b0;
			ovf_next = 1'b0;
		end
		if (int_ack) begin
			tdone_next = 1'b0;
		end
		// Shift engine
		if (!on) begin
			st_next = SPM_IDLE;
			cnt_next = 5'h00;
			sck_next = clock_idle_level;
		end else if (mst) begin
			if (st_reg == SPM_IDLE) begin
				sck_next = clock_idle_level;
				if (wr_data) begin
					sh_next = sfr_wdata;
					dout_next = first_bit(sfr_wdata, bit_order);
					st_next = SPM_RUN;
					cnt_next = 5'h00;
				end
			end else if (edge_hit) begin
				sck_next = !sck_reg;
				cnt_next = cnt_reg + 5'h01;
				if (sample) begin
					sh_next = shift_in(sh_reg, din, bit_order);
				end else begin
					dout_next = first_bit(sh_reg, bit_order);
				end
				if (cnt_reg == SPM_EDGE_LAST) begin
					st_next = SPM_IDLE;
					cnt_next = 5'h00;
					byte_done = 1'b1;
				end
			end
		end else begin
			if (!slv_sel) begin
				cnt_next = 5'h00;
				dout_next = first_bit(sh_reg, bit_order);
			end else if (edge_hit) begin
				cnt_next = cnt_reg + 5'h01;
				if (sample) begin
					sh_next = shift_in(sh_reg, din, bit_order);
				end else begin
					dout_next = first_bit(sh_reg, bit_order);
				end
				if (cnt_reg == SPM_EDGE_LAST) begin
					cnt_next = 5'h00;
					byte_done = 1'b1;
				end
			end
			if (wr_data && !busy) begin
				sh_next = sfr_wdata;
				dout_next = first_bit(sfr_wdata, bit_order);
			end
		end
		// Hardware sets win over software clears
		if (wr_data) begin
			clash_next = busy;
		end
		if (byte_done) begin
			tdone_next = 1'b1;
			full_next = 1'b1;
			if (full_reg && !rd_data) begin
				ovf_next = 1'b1;
			end
			if (mst || !full_reg || rd_data) begin
				rbuf_next = sh_next;
			end
		end
		if (fault_cond) begin
			fault_next = 1'b1;
			ctrl_next[SPM_C_ON] = 1'b0;
			ctrl_next[SPM_C_MST] = 1'b0;
			st_next = SPM_IDLE;
			cnt_next = 5'h00;
		end
	end

	// Registered outputs: pins, read data and interrupt
	always_comb begin
		pins_next.sck = sck_next;
		pins_next.sck_oe = ctrl_next[SPM_C_ON] && ctrl_next[SPM_C_MST];
		pins_next.mosi = dout_next;
		pins_next.mosi_oe = ctrl_next[SPM_C_ON] && ctrl_next[SPM_C_MST];
		pins_next.miso = dout_next;
		pins_next.miso_oe = ctrl_next[SPM_C_ON] && !ctrl_next[SPM_C_MST]
			&& (ctrl_next[SPM_C_SSIGN] || !pins_i.ss_n);
		irq_next = int_en && (tdone_next || clash_next || fault_next);
		unique case (sfr_addr)
			SPM_ADDR_CTRL: rdata_next = ctrl_reg;
			SPM_ADDR_STAT: rdata_next = {tdone_reg, clash_reg, fault_reg, ovf_reg,
				full_reg, busy, 2'b00};
			SPM_ADDR_DATA: rdata_next = rbuf_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl_reg <= SPM_CTRL_RST;
			sh_reg <= SPM_DATA_RST;
			rbuf_reg <= SPM_DATA_RST;
			rdata_reg <= 8'h00;
			cnt_reg <= 5'h00;
			st_reg <= SPM_IDLE;
			sck_reg <= 1'b0;
			dout_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
			tdone_reg <= 1'b0;
			clash_reg <= 1'b0;
			fault_reg <= 1'b0;
			ovf_reg <= 1'b0;
			full_reg <= 1'b0;
			irq_reg <= 1'b0;
			pins_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			sh_reg <= sh_next;
			rbuf_reg <= rbuf_next;
			rdata_reg <= rdata_next;
			cnt_reg <= cnt_next;
			st_reg <= st_next;
			sck_reg <= sck_next;
			dout_reg <= dout_next;
			sck_prev_reg <= pins_i.sck;
			tdone_reg <= tdone_next;
			clash_reg <= clash_next;
			fault_reg <= fault_next;
			ovf_reg <= ovf_next;
			full_reg <= full_next;
			irq_reg <= irq_next;
			pins_reg <= pins_next;
		end
	end

	assign sfr_rdata = rdata_reg;
	assign pins_o = pins_reg;
	assign irq = irq_reg;

	// Checks on the port behaviour
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	sequence s_master_start;
		on && mst && !fault_cond && (st_reg == SPM_IDLE) && wr_data;
	endsequence

	property p_fault;
		fault_cond |=> fault_reg && !on && !mst && !pins_o.sck_oe;
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault not taken");

	property p_clash;
		wr_data && busy |=> clash_reg && $stable(rbuf_reg);
	endproperty
	a_clash: assert property (p_clash) else $error("write clash not flagged");

	property p_busy_fast;
		s_master_start ##0 (ctrl_reg[1:0] == 2'b00) && !wr_ctrl
			##1 (!fault_cond && on && !wr_ctrl)[*8] ##1 (!fault_cond && on && !wr_ctrl)[*8]
			|=> (st_reg == SPM_IDLE) && tdone_reg;
	endproperty
	a_busy_fast: assert property (p_busy_fast) else $error("master byte length wrong");

	property p_rate;
		(st_reg == SPM_RUN) && tick && (ctrl_reg[1:0] == 2'b01) && !wr_ctrl
			&& (cnt_reg != SPM_EDGE_LAST) && !fault_cond |=> !tick ##1 tick;
	endproperty
	a_rate: assert property (p_rate) else $error("divide by four tick spacing wrong");

	property p_done;
		byte_done && !fault_cond |=> tdone_reg && full_reg;
	endproperty
	a_done: assert property (p_done) else $error("done or full not set");

	property p_overrun;
		byte_done && !mst && full_reg && !rd_data |=> ovf_reg && $stable(rbuf_reg);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not handled");

	property p_read_clear;
		rd_data && !byte_done |=> !full_reg && !ovf_reg && (sfr_rdata == $past(rbuf_reg));
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("data read side effects wrong");

	property p_idle_level;
		on && mst && (st_reg == SPM_IDLE) && !wr_data && !wr_ctrl && !fault_cond
			|=> pins_o.sck == $past(clock_idle_level);
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("SCK idle level wrong");

	property p_dir;
		on && !mst && !wr_ctrl |=> !pins_o.sck_oe && !pins_o.mosi_oe;
	endproperty
	a_dir: assert property (p_dir) else $error("slave drives master pins");

	property p_irq;
		int_en && fault_reg && !wr_stat |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// ---- dv/spm_peer.sv ----
`timescale 1ns/100ps
// Far-side slave; follows SCK edges directly, as a real slave would
module spm_peer (
	input wire logic sck,
	input wire logic mosi,
	input wire logic load,
	input wire logic clock_phase,
	input wire logic lsb,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	int e = 0;
	int k;
	// Load restarts the frame; phase picks sample and drive edges
	always @(posedge sck or negedge sck or posedge load) begin
		if (load) begin
			e = 0;
		end else begin
			e++;
			k = (e - 1) / 2;
			if (e[0] != clock_phase) begin
				rx[lsb ? k : 7 - k] = mosi;
			end
		end
		k = (e - clock_phase) / 2;
		k = k > 7 ? 7 : k;
		miso <= #1 tx[lsb ? k : 7 - k];
	end
endmodule

// ---- dv/tb_spi_master_slave_port.sv ----
`timescale 1ns/100ps
module tb_spi_master_slave_port import spm_pkg::*; ;
	logic clk_sys = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, int_en = 0, int_ack = 0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v, c, tx, s;
	logic m_sck = 0, m_mosi = 0, m_ss_n = 1, p_load = 0, p_miso, irq;
	logic [7:0] p_tx = 8'h00, p_rx;
	spm_pin_in_t pins_i;
	spm_pin_out_t pins_o;
	int miscompares = 0, checks_done = 0, n;
	logic [7:0] exp_q[$];
	assign pins_i = {m_sck, m_mosi, p_miso, m_ss_n};
	spm_port spm_port_i (.clk_sys, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata, .int_en, .int_ack, .pins_i, .pins_o, .irq);
	spm_peer spm_peer_i (.sck(pins_o.sck), .mosi(pins_o.mosi), .load(p_load),
		.clock_phase(c[SPM_C_CLOCK_PHASE]), .lsb(c[SPM_C_ORDER]), .tx(p_tx), .miso(p_miso), .rx(p_rx));
	// System clock
	initial forever #5 clk_sys = ~clk_sys;
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_cnt(input int g, input int e);
		checks_done++;
		if (g != e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		@(posedge clk_sys);
		d = sfr_rdata;
	endtask
	// Bench acting as external master; each SCK level lasts four clocks
	task automatic sbyte(input logic [7:0] m, output logic [7:0] r);
		for (int b = 7; b >= 0; b--) begin
			m_mosi <= m[b];
			repeat (3) @(posedge clk_sys);
			#1 r[b] = pins_o.miso;
			@(posedge clk_sys);
			m_sck <= 1'b1;
			repeat (4) @(posedge clk_sys);
			m_sck <= 1'b0;
		end
	endtask
	// Watchdog, well past the fewer than one thousand cycles the tests need
	initial begin
		#200_000;
		miscompares++;
		print_verdict;
	end
	// Main sequence
	initial begin
		void'($urandom(32'hd514));
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int a = 8'hbb; a <= 8'hbe; a++) begin
			rd(a[7:0], v);
			chk_reg(v, 8'h00);
		end
		// Master transfers over every polarity, phase, order and rate
		for (int i = 0; i < 8; i++) begin
			c = {2'b11, i[0], i[1], 1'b0, i[2], 2'(i + i / 4)};
			tx = 8'($urandom);
			int_en <= i[0];
			p_tx <= 8'($urandom);
			wr(SPM_ADDR_CTRL, c);
			repeat (2) @(posedge clk_sys);
			p_load <= 1'b1;
			exp_q.push_back(p_tx);
			@(posedge clk_sys);
			p_load <= 1'b0;
			#1 chk_reg({pins_o.sck, pins_o.sck_oe, pins_o.mosi_oe, pins_o.miso_oe}, {c[5], 3'b110});
			wr(SPM_ADDR_DATA, tx);
			sfr_addr <= SPM_ADDR_STAT;
			@(posedge clk_sys);
			#1;
			n = 0;
			while (sfr_rdata[SPM_S_BUSY] !== 1'b1 && n < 4) begin
				n++;
				@(posedge clk_sys);
				#1;
			end
			n = 0;
			while (sfr_rdata[SPM_S_BUSY] === 1'b1 && n < 600) begin
				n++;
				@(posedge clk_sys);
				#1;
			end
			chk_cnt(n, 16 << c[1:0]);
			rd(SPM_ADDR_STAT, v);
			chk_reg(v, 8'h88);
			chk_reg({7'h0, irq}, {7'h0, int_en});
			chk_reg(p_rx, tx);
			chk_reg({7'h0, pins_o.sck}, {7'h0, c[5]});
			if (i[0]) begin
				@(posedge clk_sys);
				int_ack <= 1'b1;
				@(posedge clk_sys);
				int_ack <= 1'b0;
			end else begin
				wr(SPM_ADDR_STAT, 8'h7f);
			end
			rd(SPM_ADDR_STAT, v);
			chk_reg(v, 8'h08);
			rd(SPM_ADDR_DATA, v);
			chk_reg(v, exp_q.pop_front());
			rd(SPM_ADDR_STAT, v);
			chk_reg(v, 8'h00);
		end
		// Select pulled low while master: fault drops on and master
		wr(SPM_ADDR_CTRL, 8'hc0);
		m_ss_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(SPM_ADDR_STAT, v);
		chk_reg(v, 8'h20);
		chk_reg({7'h0, irq}, 8'h01);
		rd(SPM_ADDR_CTRL, v);
		chk_reg(v, 8'h00);
		chk_reg({5'h0, pins_o.sck_oe, pins_o.mosi_oe, pins_o.miso_oe}, 8'h00);
		m_ss_n <= 1'b1;
		wr(SPM_ADDR_STAT, 8'hdf);
		rd(SPM_ADDR_STAT, v);
		chk_reg(v, 8'h00);
		// Slave with select ignored is always busy, so writes clash
		wr(SPM_ADDR_CTRL, 8'h88);
		wr(SPM_ADDR_DATA, 8'h5a);
		rd(SPM_ADDR_STAT, v);
		chk_reg(v, 8'h44);
		// Honoured select: idle write clears clash, two bytes overrun
		wr(SPM_ADDR_CTRL, 8'h83);
		tx = 8'($urandom);
		wr(SPM_ADDR_DATA, tx);
		rd(SPM_ADDR_STAT, v);
		chk_reg(v, 8'h00);
		m_ss_n <= 1'b0;
		rd(SPM_ADDR_STAT, v);
		chk_reg(v, 8'h04);
		c = 8'($urandom);
		sbyte(c, s);
		chk_reg(s, tx);
		chk_reg({6'h0, pins_o.sck_oe, pins_o.miso_oe}, 8'h01);
		sbyte(~c, s);
		rd(SPM_ADDR_STAT, v);
		chk_reg(v, 8'h9c);
		m_ss_n <= 1'b1;
		rd(SPM_ADDR_DATA, v);
		chk_reg(v, c);
		print_verdict;
	end
endmodule
